// ### rtl/rlt_map.svh
// Purpose: register offsets, field positions and reset values of the timer
// Assumes: byte addresses on a 32-bit bus, one register per aligned word
// Notes:   definitions only
`ifndef RLT_MAP_SVH
`define RLT_MAP_SVH

// --------------------------------
// register offsets
// --------------------------------
`define RLT_OFS_CTRL        8'h00
`define RLT_OFS_COUNT_HIGH  8'h04
`define RLT_OFS_COUNT_LOW   8'h08
`define RLT_OFS_RELOAD      8'h0c
`define RLT_OFS_CAPTURE     8'h10
`define RLT_OFS_STATUS      8'h14

// --------------------------------
// timer_control_one fields
// --------------------------------
`define RLT_CTRL_EN_BIT     0
`define RLT_CTRL_MODE_LSB   1
`define RLT_CTRL_MODE_MSB   3
`define RLT_CTRL_PRE_LSB    4
`define RLT_CTRL_PRE_MSB    6
`define RLT_CTRL_POL_BIT    7
`define RLT_CTRL_ISEL_LSB   8
`define RLT_CTRL_ISEL_MSB   9

// --------------------------------
// status fields
// --------------------------------
`define RLT_STAT_EN_BIT     0
`define RLT_STAT_WAIT_BIT   1
`define RLT_STAT_OUT_BIT    2

// --------------------------------
// reset and restart values
// --------------------------------
`define RLT_COUNT_RST       16'h0000
`define RLT_RELOAD_RST      16'hffff
`define RLT_CAPTURE_RST     16'h0000
`define RLT_COUNT_RESTART   16'h0001
`define RLT_PRE_RST         3'h0

`endif

// ### rtl/rlt_pkg.sv
// Purpose: types shared by the timer files
// Assumes: nothing
// Notes:   mode order is the encoding of the control mode field
package rlt_pkg;

    typedef logic [31:0] rlt_word_t;
    typedef logic [15:0] rlt_count_t;

    typedef enum logic [2:0] {
        RLT_ONESHOT,
        RLT_CONTINUOUS,
        RLT_COUNTER,
        RLT_CAPTURE,
        RLT_COMPARE,
        RLT_CAPCMP,
        RLT_DUALPWM
    } rlt_mode_t;

    typedef enum logic [1:0] {
        RLT_ISEL_BOTH,
        RLT_ISEL_BOTH_ALT,
        RLT_ISEL_CAPTURE,
        RLT_ISEL_RELOAD
    } rlt_isel_t;

endpackage : rlt_pkg

// ### rtl/rlt_prescale.sv
// Purpose: divides count steps by 1, 2, 4 .. 128
// Assumes: step is a one-cycle pulse or held high for sys_clk counting
// Notes:   tick is combinational and coincides with the last step
`timescale 1ns/10ps
module rlt_prescale (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       run,
    input  wire logic       step,
    input  wire logic [2:0] divSel,
    output logic            tick
);
    logic [6:0] stepCount;
    logic [7:0] divisor;
    logic [6:0] limit;

    assign divisor = 8'h01 << divSel;
    assign limit   = 7'(divisor - 8'h01);
    assign tick    = run & step & (stepCount == limit);

    // restarts from zero whenever the timer stops, so each start is exact
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            stepCount <= 7'h00;
        end else if (!run) begin
            stepCount <= 7'h00;
        end else if (step) begin
            stepCount <= tick ? 7'h00 : 7'(stepCount + 7'h01);
        end
    end
endmodule : rlt_prescale

// ### rtl/rlt_sync.sv
// Purpose: brings the timer input pin into the sys_clk domain
// Assumes: pin toggles at no more than a quarter of sys_clk
// Notes:   a new level is taken once the second and third stage agree
`timescale 1ns/10ps
module rlt_sync (
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic pinIn,
    output logic      level
);
    logic stage1;
    logic stage2;
    logic stage3;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            level <= 1'b0;
        end else if (stage2 == stage3) begin
            level <= stage3;
        end
    end
endmodule : rlt_sync

// ### rtl/rlt_timer16.sv
// Purpose: 16-bit reloadable timer with prescaler, capture and compare
// Assumes: AHB-Lite single word transfers; timer pin already muxed in
// Notes:   one wait state on every transfer; timerIrq is a one-cycle pulse
//
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "rlt_map.svh"

// Notes on behaviour
// - one 16-bit reloadable counter for timing, event counting or output.
// - prescaler divides count steps by 1 up to 128.
// - one-shot reload flips the output pin for exactly one cycle.
// - one-shot always counts prescaled sys_clk, never the input pin.
// - one-shot period is (reload minus start) times prescale cycles.
// - continuous mode reloads to 0001h at reload value, raises interrupt.
// - continuous mode toggles the output pin at every reload.
// - capture interrupt source selectable: both, capture only, reload only.
// - capture value minus start, times prescale, gives elapsed cycles.
// - compare mode interrupts at match and keeps counting without reload.
// - compare mode toggles the output pin at every match.
// - compare mode wraps from ffffh to 0000h.
// - capture/compare starts on first input edge; that edge gives no interrupt.
// - enabled high-byte read latches low byte; low read returns held copy.
// - disabled low-byte read returns the live counter.
// - reads never disturb counting, reloads, interrupts or output.
// - input shares the pin; used only in counter and capture modes, gated off in dual output mode.
module rlt_timer16 (
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    input  wire logic              hsel,
    input  wire rlt_pkg::rlt_word_t haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire rlt_pkg::rlt_word_t hwdata,
    input  wire logic              hready,
    output rlt_pkg::rlt_word_t     hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              timerInPin,
    output logic                   timerOut,
    output logic                   timerOutN,
    output logic                   timerIrq
);
    import rlt_pkg::*;

    // --------------------------------
    // declarations
    // --------------------------------
    logic       busy;
    logic       busWrite;
    logic [7:0] busAddr;
    logic       accept;
    logic       wrAct;
    logic       rdAct;
    logic       ctrlWrite;

    logic       timerEnable;
    rlt_mode_t  mode;
    logic [2:0] prescaleSel;
    logic       outputPolarity;
    rlt_isel_t  intSource;
    rlt_count_t count;
    rlt_count_t reloadValue;
    rlt_count_t captureValue;
    logic [7:0] holdLow;
    logic       waitFirstEdge;

    logic       inLevel;
    logic       inPrev;
    logic       inputAllowed;
    logic       inEdge;
    logic       countsInput;
    logic       running;
    logic       stepIn;
    logic       tick;
    rlt_count_t nextCount;
    logic       hitReload;
    logic       capMode;
    logic       reloadEv;
    logic       compareEv;
    logic       captureEv;
    logic       firstEdge;
    logic       next_outLevel;

    // --------------------------------
    // bus slave
    // --------------------------------
    // hsize is not checked: only whole word accesses are supported
    assign accept    = hsel & htrans[1] & hready & ~busy;
    assign wrAct     = busy & busWrite;
    assign rdAct     = busy & ~busWrite;
    assign ctrlWrite = wrAct & (busAddr == `RLT_OFS_CTRL);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            busy     <= 1'b0;
            busWrite <= 1'b0;
            busAddr  <= 8'h00;
        end else begin
            busy <= accept;
            if (accept) begin
                busWrite <= hwrite;
                busAddr  <= haddr[7:0];
            end
        end
    end

    // one wait state lets hrdata come from a register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            hreadyout <= 1'b1;
        end else if (accept) begin
            hreadyout <= 1'b0;
        end else if (busy) begin
            hreadyout <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // read data; unmapped offsets read zero
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rdAct) begin
            hrdata <= 32'h0000_0000;
            case (busAddr)
                `RLT_OFS_CTRL: begin
                    hrdata[`RLT_CTRL_EN_BIT]                      <= timerEnable;
                    hrdata[`RLT_CTRL_MODE_MSB:`RLT_CTRL_MODE_LSB] <= mode;
                    hrdata[`RLT_CTRL_PRE_MSB:`RLT_CTRL_PRE_LSB]   <= prescaleSel;
                    hrdata[`RLT_CTRL_POL_BIT]                     <= outputPolarity;
                    hrdata[`RLT_CTRL_ISEL_MSB:`RLT_CTRL_ISEL_LSB] <= intSource;
                end
                `RLT_OFS_COUNT_HIGH: hrdata[7:0] <= count[15:8];
                `RLT_OFS_COUNT_LOW:  hrdata[7:0] <= timerEnable ? holdLow
                                                                : count[7:0];
                `RLT_OFS_RELOAD:     hrdata[15:0] <= reloadValue;
                `RLT_OFS_CAPTURE:    hrdata[15:0] <= captureValue;
                `RLT_OFS_STATUS: begin
                    hrdata[`RLT_STAT_EN_BIT]   <= timerEnable;
                    hrdata[`RLT_STAT_WAIT_BIT] <= waitFirstEdge;
                    hrdata[`RLT_STAT_OUT_BIT]  <= timerOut;
                end
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // --------------------------------
    // control register
    // --------------------------------
    // a software write wins over the one-shot self stop in the same cycle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            timerEnable    <= 1'b0;
            mode           <= RLT_ONESHOT;
            prescaleSel    <= `RLT_PRE_RST;
            outputPolarity <= 1'b0;
            intSource      <= RLT_ISEL_BOTH;
        end else if (ctrlWrite) begin
            timerEnable    <= hwdata[`RLT_CTRL_EN_BIT];
            mode           <= rlt_mode_t'(hwdata[`RLT_CTRL_MODE_MSB:`RLT_CTRL_MODE_LSB]);
            prescaleSel    <= hwdata[`RLT_CTRL_PRE_MSB:`RLT_CTRL_PRE_LSB];
            outputPolarity <= hwdata[`RLT_CTRL_POL_BIT];
            intSource      <= rlt_isel_t'(hwdata[`RLT_CTRL_ISEL_MSB:`RLT_CTRL_ISEL_LSB]);
        end else if (reloadEv && mode == RLT_ONESHOT) begin
            timerEnable <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reloadValue <= `RLT_RELOAD_RST;
        end else if (wrAct && busAddr == `RLT_OFS_RELOAD) begin
            reloadValue <= hwdata[15:0];
        end
    end

    // --------------------------------
    // input pin
    // --------------------------------
    rlt_sync u_sync (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .pinIn   (timerInPin),
        .level   (inLevel)
    );

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            inPrev <= 1'b0;
        end else begin
            inPrev <= inLevel;
        end
    end

    // polarity low selects rising edges, high selects falling edges
    assign inputAllowed = (mode != RLT_DUALPWM);
    assign inEdge       = inputAllowed & (inLevel != inPrev) & (inLevel == ~outputPolarity);
    assign capMode      = (mode == RLT_CAPTURE) | (mode == RLT_CAPCMP);
    assign countsInput  = (mode == RLT_COUNTER);

    // --------------------------------
    // counting
    // --------------------------------
    assign running = timerEnable & ~waitFirstEdge;
    assign stepIn  = countsInput ? inEdge : 1'b1;

    rlt_prescale u_pre (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .run     (running),
        .step    (stepIn),
        .divSel  (prescaleSel),
        .tick    (tick)
    );

    // period is exactly reload minus start ticks
    assign nextCount = 16'(count + 16'h0001);
    assign hitReload = tick & (nextCount == reloadValue);
    assign reloadEv  = hitReload & (mode != RLT_COMPARE);
    assign compareEv = hitReload & (mode == RLT_COMPARE);
    assign captureEv = running & capMode & inEdge;
    assign firstEdge = timerEnable & waitFirstEdge & inEdge;

    // bus writes take the count over; reads never touch it
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            count <= `RLT_COUNT_RST;
        end else if (wrAct && busAddr == `RLT_OFS_COUNT_HIGH) begin
            count[15:8] <= hwdata[7:0];
        end else if (wrAct && busAddr == `RLT_OFS_COUNT_LOW) begin
            count[7:0] <= hwdata[7:0];
        end else if (captureEv && mode == RLT_CAPCMP) begin
            count <= `RLT_COUNT_RESTART;
        end else if (reloadEv) begin
            count <= `RLT_COUNT_RESTART;
        end else if (tick) begin
            count <= nextCount;
        end
    end

    // armed by the mode write, released by the first qualifying edge
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            waitFirstEdge <= 1'b0;
        end else if (ctrlWrite) begin
            waitFirstEdge <= (hwdata[`RLT_CTRL_MODE_MSB:`RLT_CTRL_MODE_LSB]
                              == 3'(RLT_CAPCMP));
        end else if (firstEdge) begin
            waitFirstEdge <= 1'b0;
        end
    end

    // --------------------------------
    // capture and holding registers
    // --------------------------------
    // a capture in the cycle of a software clear is kept
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            captureValue <= `RLT_CAPTURE_RST;
        end else if (captureEv) begin
            captureValue <= count;
        end else if (wrAct && busAddr == `RLT_OFS_CAPTURE) begin
            captureValue <= hwdata[15:0];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            holdLow <= 8'h00;
        end else if (rdAct && busAddr == `RLT_OFS_COUNT_HIGH && timerEnable) begin
            holdLow <= count[7:0];
        end
    end

    // --------------------------------
    // interrupt pulse
    // --------------------------------
    // source select only narrows the capture modes
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            timerIrq <= 1'b0;
        end else begin
            timerIrq <= (reloadEv & ~(capMode & intSource == RLT_ISEL_CAPTURE))
                      | (captureEv & (intSource != RLT_ISEL_RELOAD))
                      | compareEv;
        end
    end

    // --------------------------------
    // output pin
    // --------------------------------
    // while stopped the pin rests at the polarity level; the one-shot stops
    // itself on reload, so its flip returns to that level one cycle later
    always_comb begin
        next_outLevel = timerOut;
        if (!timerEnable) begin
            next_outLevel = outputPolarity;
        end else if (reloadEv || compareEv) begin
            next_outLevel = ~timerOut;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            timerOut  <= 1'b0;
            timerOutN <= 1'b1;
        end else begin
            timerOut  <= next_outLevel;
            timerOutN <= ~next_outLevel;
        end
    end

endmodule : rlt_timer16

// ### sim/rlt_pin_model.sv
// Purpose: outside source on the timer input pin
// Assumes: shares sys_clk with the timer
// Notes:   every level lasts at least four clocks
`timescale 1ns/10ps
module rlt_pin_model (
    input  wire logic sys_clk,
    input  wire logic toggleEn,
    output logic      timerInPin
);
    logic [1:0] phase;
    initial begin
        timerInPin = 1'b0;
        phase = 2'h0;
    end
    // free toggling at an eighth of sys_clk, well inside the input limit
    always @(posedge sys_clk) begin
        phase <= phase + 2'h1;
        if (toggleEn && phase == 2'h3)
            timerInPin <= ~timerInPin;
    end
    task automatic drive(input logic level);
        @(posedge sys_clk);
        timerInPin <= level;
        repeat (4) @(posedge sys_clk);
    endtask : drive
endmodule : rlt_pin_model

// ### sim/rlt_timer16_assertions.sv
// Purpose: port-level checks of the reloadable timer
// Assumes: a bus write takes effect at the edge that ends its wait state
// Notes:   ctrl and reload are shadowed from the bus writes it observes
`timescale 1ns/10ps
`include "rlt_map.svh"
module rlt_timer16_checker (
    input wire logic               sys_clk,
    input wire logic               resetn,
    input wire logic               hsel,
    input wire rlt_pkg::rlt_word_t haddr,
    input wire logic [1:0]         htrans,
    input wire logic               hwrite,
    input wire logic [2:0]         hsize,
    input wire rlt_pkg::rlt_word_t hwdata,
    input wire logic               hready,
    input wire rlt_pkg::rlt_word_t hrdata,
    input wire logic               hreadyout,
    input wire logic               hresp,
    input wire logic               timerInPin,
    input wire logic               timerOut,
    input wire logic               timerOutN,
    input wire logic               timerIrq
);
    import rlt_pkg::*;
    logic        pendWr;
    logic [7:0]  pendAddr;
    logic        apply;
    rlt_mode_t   mode;
    logic [2:0]  pre;
    rlt_count_t  rel;
    logic [23:0] gap;
    logic        gapOk;
    logic        osSeen;
    logic        pol;

    // ----------------
    // shadow of configuration and irq spacing
    // ----------------
    assign apply = pendWr && !hreadyout;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pendWr <= 1'b0;
            pendAddr <= 8'h00;
        end else if (hsel && htrans[1] && hready) begin
            pendWr <= hwrite;
            pendAddr <= haddr[7:0];
        end else if (apply) begin
            pendWr <= 1'b0;
        end
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mode <= RLT_ONESHOT;
            pre <= 3'h0;
            rel <= 16'hffff;
            pol <= 1'b0;
        end else if (apply && pendAddr == `RLT_OFS_CTRL) begin
            mode <= rlt_mode_t'(hwdata[3:1]);
            pre <= hwdata[6:4];
            pol <= hwdata[7];
        end else if (apply && pendAddr == `RLT_OFS_RELOAD) begin
            rel <= hwdata[15:0];
        end
    end
    // any write spoils the spacing measurement; reads must not
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gap <= 24'h0;
            gapOk <= 1'b0;
            osSeen <= 1'b0;
        end else begin
            gap <= timerIrq ? 24'h1 : gap + 24'h1;
            gapOk <= apply ? 1'b0 : (timerIrq ? 1'b1 : gapOk);
            osSeen <= apply ? 1'b0 : (timerIrq ? 1'b1 : osSeen);
        end
    end

    // ----------------
    // properties
    // ----------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_flip_back;
        $changed(timerOut) ##1 timerOut == pol;
    endsequence
    sequence s_wait_state;
        !hreadyout ##1 hreadyout;
    endsequence
    property p_oneshot_pulse;
        timerIrq && mode == RLT_ONESHOT |-> s_flip_back;
    endproperty
    a_oneshot_pulse: assert property (p_oneshot_pulse)
        else $error("one-shot pulse width wrong");
    property p_oneshot_once;
        timerIrq && mode == RLT_ONESHOT |-> !osSeen;
    endproperty
    a_oneshot_once: assert property (p_oneshot_once)
        else $error("one-shot fired twice");
    property p_cont_toggle;
        timerIrq && mode == RLT_CONTINUOUS |-> $changed(timerOut);
    endproperty
    a_cont_toggle: assert property (p_cont_toggle)
        else $error("no toggle at reload");
    property p_cont_period;
        timerIrq && gapOk && mode == RLT_CONTINUOUS |-> gap == (24'(rel) - 24'h1) << pre;
    endproperty
    a_cont_period: assert property (p_cont_period)
        else $error("reload spacing wrong");
    property p_cmp_toggle;
        timerIrq && mode == RLT_COMPARE |-> $changed(timerOut);
    endproperty
    a_cmp_toggle: assert property (p_cmp_toggle)
        else $error("no toggle at match");
    property p_cmp_period;
        timerIrq && gapOk && mode == RLT_COMPARE |-> gap == 24'h010000 << pre;
    endproperty
    a_cmp_period: assert property (p_cmp_period)
        else $error("match spacing not a wrap");
    property p_out_compl;
        timerOutN != timerOut;
    endproperty
    a_out_compl: assert property (p_out_compl)
        else $error("outputs not complementary");
    property p_bus_wait;
        hsel && htrans[1] && hready |=> s_wait_state;
    endproperty
    a_bus_wait: assert property (p_bus_wait)
        else $error("not one wait state");
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay)
        else $error("response not okay");
endmodule : rlt_timer16_checker

bind rlt_timer16 rlt_timer16_checker u_chk (
    .sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .timerInPin(timerInPin), .timerOut(timerOut),
    .timerOutN(timerOutN), .timerIrq(timerIrq)
);

// ### sim/test_reloadable_timer_16bit.sv
// Purpose: self-checking bench of the reloadable timer
// Assumes: one wait state per bus transfer, irq a one-cycle pulse
// Notes:   irq spacing is measured in clock edges between pulses
`timescale 1ns/10ps
module test_reloadable_timer_16bit;
    import rlt_pkg::*;
    logic       sys_clk, resetn, hsel, hwrite, hreadyout, hresp, toggleEn;
    logic       timerInPin, timerOut, timerOutN, timerIrq, lvl;
    logic [1:0] htrans;
    logic [2:0] hsize;
    rlt_word_t  haddr, hwdata, hrdata, rdv, held;
    int         n_fail, cmp_count, cyc, c0, i;
    logic [1:0] iselTab [3] = '{2'h0, 2'h2, 2'h3};

    always #5 sys_clk = ~sys_clk;

    rlt_timer16 uut (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .timerInPin(timerInPin), .timerOut(timerOut), .timerOutN(timerOutN),
        .timerIrq(timerIrq));
    rlt_pin_model pin (.sys_clk(sys_clk), .toggleEn(toggleEn), .timerInPin(timerInPin));

    // ----------------
    // tasks
    // ----------------
    task automatic summarize;
        if (n_fail == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize
    task automatic hang(input string what);
        n_fail++;
        $display("Error %s expected response seen timeout", what);
        summarize();
    endtask : hang
    task automatic check(input string what, input rlt_word_t seen, input rlt_word_t exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [7:0] a, input rlt_word_t wd);
        int n;
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        for (int ph = 0; ph < 2; ph++) begin
            n = 0;
            do begin
                @(posedge sys_clk);
                n++;
            end while (hreadyout !== 1'b1 && n < 20);
            if (hreadyout !== 1'b1)
                hang("bus");
            hsel <= 1'b0;
            htrans <= 2'b00;
            hwdata <= wd;
        end
        rdv = hrdata;
    endtask : bus
    task automatic rdchk(input string what, input logic [7:0] a, input rlt_word_t exp);
        bus(1'b0, a, 32'h0);
        check(what, rdv, exp);
    endtask : rdchk
    task automatic waitIrq(input int lim);
        cyc = 0;
        do begin
            @(posedge sys_clk);
            cyc++;
        end while (timerIrq !== 1'b1 && cyc < lim);
        if (timerIrq !== 1'b1)
            hang("irq");
    endtask : waitIrq
    // the capture clear is harmless outside the capture modes
    task automatic setup(input rlt_mode_t m, input logic [2:0] p, input logic [1:0] is,
                         input rlt_count_t st, input rlt_count_t rl);
        bus(1'b1, 8'h00, {22'h0, is, 1'b0, p, m, 1'b0});
        bus(1'b1, 8'h04, {24'h0, st[15:8]});
        bus(1'b1, 8'h08, {24'h0, st[7:0]});
        bus(1'b1, 8'h0c, {16'h0, rl});
        bus(1'b1, 8'h10, 32'h0);
        bus(1'b1, 8'h00, {22'h0, is, 1'b0, p, m, 1'b1});
    endtask : setup

    // ----------------
    // scenarios
    // ----------------
    initial begin
        sys_clk = 1'b0;
        resetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        toggleEn = 1'b0;
        n_fail = 0;
        cmp_count = 0;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        check("pins", {30'h0, timerOutN, timerOut}, 32'h2);
        for (i = 0; i < 7; i++)
            rdchk("reset", 8'(i * 4), i == 3 ? 32'hffff : 32'h0);
        bus(1'b1, 8'h18, 32'h5a5a);
        rdchk("unmapped", 8'h18, 32'h0);
        bus(1'b1, 8'h04, 32'h12);
        bus(1'b1, 8'h08, 32'h34);
        rdchk("live lo", 8'h08, 32'h34);
        rdchk("live hi", 8'h04, 32'h12);
        for (i = 0; i < 8; i += 7) begin
            setup(RLT_CONTINUOUS, 3'(i), 2'h0, 16'h1, 16'h5);
            waitIrq(2000);
            lvl = timerOut;
            waitIrq(2000);
            check("cont period", cyc, 4 << i);
            check("cont out", 32'(timerOut), 32'(!lvl));
        end
        setup(RLT_CONTINUOUS, 3'h7, 2'h0, 16'h1, 16'hffff);
        bus(1'b0, 8'h04, 32'h0);
        bus(1'b0, 8'h08, 32'h0);
        held = rdv;
        repeat (300) @(posedge sys_clk);
        rdchk("held lo", 8'h08, held);
        bus(1'b0, 8'h04, 32'h0);
        bus(1'b0, 8'h08, 32'h0);
        check("count moved", 32'(rdv != held), 32'h1);
        for (i = 0; i < 2; i++) begin
            toggleEn <= (i == 1);
            setup(RLT_ONESHOT, 3'h2, 2'h0, 16'h2, 16'(6 + 4 * i));
            bus(1'b1, 8'h00, {24'h0, 1'(i), 3'h2, RLT_ONESHOT, 1'b1});
            waitIrq(500);
            c0 = (i == 0) ? cyc : c0;
            rdchk("os status", 8'h14, 32'(i * 4));
            rdchk("os count", 8'h08, 32'h1);
        end
        toggleEn <= 1'b0;
        check("os period", cyc - c0, 32'd16);
        setup(RLT_COMPARE, 3'h0, 2'h0, 16'hfffa, 16'h5);
        waitIrq(100);
        lvl = timerOut;
        waitIrq(70000);
        check("cmp period", cyc, 32'h10000);
        check("cmp out", 32'(timerOut), 32'(!lvl));
        bus(1'b0, 8'h04, 32'h0);
        bus(1'b0, 8'h08, 32'h0);
        check("cmp kept", 32'(rdv > 32'h1), 32'h1);
        for (i = 0; i < 3; i++) begin
            pin.drive(1'b0);
            setup(RLT_CAPTURE, 3'h0, iselTab[i], 16'h1, 16'h0100);
            pin.drive(1'b1);
            waitIrq(600);
            check("irq source", 32'(cyc < 50), 32'(i < 2));
            bus(1'b0, 8'h10, 32'h0);
            check("capture", 32'(rdv > 32'h0 && rdv < 32'h20), 32'h1);
        end
        pin.drive(1'b0);
        setup(RLT_CAPCMP, 3'h0, 2'h0, 16'h1, 16'h0030);
        rdchk("waiting", 8'h14, 32'h3);
        pin.drive(1'b1);
        waitIrq(300);
        check("first edge", 32'(cyc > 30), 32'h1);
        toggleEn <= 1'b1;
        setup(RLT_COUNTER, 3'h0, 2'h0, 16'h1, 16'h3);
        waitIrq(300);
        waitIrq(300);
        check("edges", cyc, 32'd16);
        summarize();
    end
endmodule : test_reloadable_timer_16bit
